// File: inc/hmi_regs.svh
// constants for the hardware monitor interrupt logic
`ifndef HMI_REGS_SVH
`define HMI_REGS_SVH
// ************
// bit positions
// ************
`define HMI_CFG1_START 0
`define HMI_CFG1_INT_EN 1
`define HMI_CFG1_THERMAL_ALARM_N_EN 2
`define HMI_CFG1_INT_CLR 3
`define HMI_CFG1_RST_GO 4
`define HMI_CFG1_THERMAL_ALARM_N_CLR 6
`define HMI_CFG2_TEMP_MASK 0
`define HMI_CFG2_ACPI 3
`define HMI_CFG2_REQ3_EN 6
`define HMI_CFG2_REQ4_EN 7
`define HMI_CHM_REQ_MODE 7
`define HMI_CHM_REQ_EN_LO 4
`define HMI_MSK2_RST_EN 7
`define HMI_ST2_THERMAL_ALARM_N_BIT 5
// ************
// values and timing
// ************
`define HMI_FAN_FULL 8'hFF
`define HMI_TRIP_CONSEC 2'h3
`define HMI_HYST_DEG 8'h05
`define HMI_RST_PULSE_MS 20
`define HMI_CLK_HZ 25000000
`define HMI_RST_PULSE_CYC ((`HMI_RST_PULSE_MS * (`HMI_CLK_HZ / 1000)))
`endif

// File: inc/hmi_pkg.sv
// types for the hardware monitor interrupt logic
package hmi_pkg;
  typedef enum logic [1:0] {
    HMI_PULSE_IDLE = 2'b01,
    HMI_PULSE_LOW = 2'b10
  } hmi_pulse_st_t;
endpackage

// File: hdl/hmi_trip.sv
// hardware trip filter for one sensor: three-in-a-row assert and release
`timescale 1ns/100ps
`include "hmi_regs.svh"
module hmi_trip #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic soft_rst_i,
  input wire logic cmp_i,
  input wire logic [W-1:0] temp_i,
  input wire logic [W-1:0] limit_i,
  input wire logic clear_i,
  output logic trip_o
);
  logic [1:0] over_cnt_r;
  logic [1:0] under_cnt_r;
  logic trip_r;
  wire over = temp_i > limit_i;
  // 5 degree hysteresis, guarded against a limit below 5
  wire [W:0] rel_lvl = {1'b0, limit_i} - {{(W-7){1'b0}}, `HMI_HYST_DEG};
  wire under = !rel_lvl[W] && ({1'b0, temp_i} <= rel_lvl);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      over_cnt_r <= 2'h0;
      under_cnt_r <= 2'h0;
      trip_r <= 1'b0;
    end else if (soft_rst_i || clear_i) begin
      over_cnt_r <= 2'h0;
      under_cnt_r <= 2'h0;
      trip_r <= 1'b0;
    end else if (cmp_i) begin
      over_cnt_r <= over ? ((over_cnt_r == `HMI_TRIP_CONSEC) ? over_cnt_r : over_cnt_r + 2'h1) : 2'h0;
      under_cnt_r <= under ? ((under_cnt_r == `HMI_TRIP_CONSEC) ? under_cnt_r : under_cnt_r + 2'h1) : 2'h0;
      if (over && over_cnt_r == `HMI_TRIP_CONSEC - 2'h1) begin
        trip_r <= 1'b1;
      end else if (under && under_cnt_r == `HMI_TRIP_CONSEC - 2'h1) begin
        trip_r <= 1'b0;
      end
    end
  end
  assign trip_o = trip_r;
endmodule // hmi_trip

// File: hdl/hmi_top.sv
// interrupt and thermal alarm logic of a hardware monitor
//
// How it works
// - a set mask bit blocks its status bit from the interrupt
// - unmasked status bits are OR'd onto the active-low interrupt
// - interrupt only drives while enable is one and clear is zero
// - channel mode bit 7 turns volt-id inputs into request inputs
// - requests are unlatched levels; 0-2 active low, 3-4 active high
// - each request has an enable: mode bits 4-6, config2 bits 6-7
// - reading a status register returns it then clears it
// - interrupt clear bit drops the output, status kept
// - mirror registers copy every status update, never cleared by reads
// - in default mode, temperature over high or hardware trip raises interrupt
// - temperature interrupt re-raised only on a new crossing or a high/low limit change
// - external low on thermal alarm pin sets status2 bit 5
// - config1 bit 2 enables alarm; config2 bit 3 picks ACPI mode
// - config2 bit 0 masks temperature from the interrupt and, outside ACPI mode, clears trip errors
// - external low on thermal alarm forces fan code to FFh
// - default mode alarm follows high limit, released by read, clear, low limit
// - read-cleared alarm returns next compare; bit 6 holds it off
// - three trip-limit exceedances assert alarm and force FFh
// - trip errors survive reads; cleared by config2 bit 0 outside ACPI mode, or hysteresis
// - ACPI mode alarm follows only trip limits, forcing FFh
// - config1 bit 4 gives 20 ms reset pulse if mask2 bit 7 set
// - reset pin low reloads defaulted registers, not values or limits
`timescale 1ns/100ps
`include "hmi_regs.svh"
module hmi_top
  import hmi_pkg::*;
#(
  parameter int NSTAT = 16,
  parameter int NTEMP = 2,
  parameter int TW = 8,
  parameter int RST_CYC = `HMI_RST_PULSE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] cfg1_i,
  input wire logic cfg1_we_i,
  input wire logic [7:0] cfg2_i,
  input wire logic [7:0] chan_mode_i,
  input wire logic [NSTAT-1:0] int_mask_i,
  input wire logic rst_pulse_en_i,
  input wire logic [NSTAT-1:0] meas_upd_i,
  input wire logic [NSTAT-1:0] meas_oor_i,
  input wire logic [NTEMP-1:0] temp_cmp_i,
  input wire logic [NTEMP*TW-1:0] temp_i,
  input wire logic [NTEMP*TW-1:0] temp_high_i,
  input wire logic [NTEMP*TW-1:0] temp_low_i,
  input wire logic [NTEMP*TW-1:0] trip_lim_i,
  input wire logic [NTEMP*TW-1:0] fixed_trip_i,
  input wire logic [1:0] stat_rd_i,
  input wire logic [4:0] volt_id_i,
  input wire logic thermal_alarm_n_i,
  input wire logic ext_rst_n_i,
  input wire logic [7:0] fan_code_i,
  output logic [NSTAT-1:0] int_stat_o,
  output logic [NSTAT-1:0] int_mirror_o,
  output logic [NTEMP-1:0] trip_err_o,
  output logic [4:0] ext_req_o,
  output logic int_oe_o,
  output logic thermal_alarm_n_oe_o,
  output logic reset_oe_o,
  output logic rst_go_done_o,
  output logic soft_rst_o,
  output logic [7:0] fan_code_o
);
  localparam int HALF = NSTAT / 2;
  localparam int THERMAL_ALARM_N_IDX = HALF + `HMI_ST2_THERMAL_ALARM_N_BIT;
  localparam logic [24:0] RST_LAST = 25'(RST_CYC - 1);
  // ************
  // reset pin input
  // ************
  logic ext_rst_r;
  logic soft_rst_r;
  // reset pin reloads control state; values and limits live outside
  wire soft_rst = !ext_rst_n_i && !reset_oe_o;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_rst_r <= 1'b0;
      soft_rst_r <= 1'b0;
    end else begin
      ext_rst_r <= soft_rst;
      soft_rst_r <= soft_rst && !ext_rst_r;
    end
  end
  // ************
  // decode of control bits
  // ************
  wire int_en = cfg1_i[`HMI_CFG1_INT_EN];
  wire int_clr = cfg1_i[`HMI_CFG1_INT_CLR];
  wire thermal_alarm_n_en = cfg1_i[`HMI_CFG1_THERMAL_ALARM_N_EN];
  wire thermal_alarm_n_clr = cfg1_i[`HMI_CFG1_THERMAL_ALARM_N_CLR];
  wire temp_mask = cfg2_i[`HMI_CFG2_TEMP_MASK];
  wire acpi = cfg2_i[`HMI_CFG2_ACPI];
  wire req_mode = chan_mode_i[`HMI_CHM_REQ_MODE];
  wire [4:0] req_en = {cfg2_i[`HMI_CFG2_REQ4_EN], cfg2_i[`HMI_CFG2_REQ3_EN],
                       chan_mode_i[`HMI_CHM_REQ_EN_LO+2:`HMI_CHM_REQ_EN_LO]};
  wire [4:0] req_act = {volt_id_i[4:3], ~volt_id_i[2:0]};
  wire [4:0] ext_req = req_act & req_en & {5{req_mode}};
  wire ext_thermal_alarm_n = !thermal_alarm_n_i && !thermal_alarm_n_oe_o;
  // ************
  // per-sensor temperature tracking
  // ************
  logic [NTEMP-1:0] trip_w;
  logic [NTEMP-1:0] hi_w;
  logic [NTEMP-1:0] lo_w;
  logic [NTEMP-1:0] side_hi_r;
  logic [NTEMP-1:0] side_lo_r;
  logic [NTEMP-1:0] new_hi_w;
  logic [NTEMP-1:0] new_lo_w;
  logic [NTEMP*TW-1:0] hi_last_r;
  logic [NTEMP*TW-1:0] lo_last_r;
  logic [NTEMP-1:0] trip_hi_w;
  logic [NTEMP-1:0] side_trip_r;
  logic [NTEMP-1:0] new_trip_w;
  wire trip_clr = cfg2_i[`HMI_CFG2_TEMP_MASK] && !acpi;
  genvar g;
  generate
    for (g = 0; g < NTEMP; g = g + 1) begin : g_temp
      wire [TW-1:0] t = temp_i[g*TW +: TW];
      wire [TW-1:0] hl = temp_high_i[g*TW +: TW];
      wire [TW-1:0] ll = temp_low_i[g*TW +: TW];
      wire [TW-1:0] tl = trip_lim_i[g*TW +: TW];
      wire [TW-1:0] fl = fixed_trip_i[g*TW +: TW];
      // lower of the programmable and fixed trip wins
      wire [TW-1:0] eff = (tl < fl) ? tl : fl;
      assign hi_w[g] = t > hl;
      assign lo_w[g] = t < ll;
      // a repeat on the same side only raises after a limit change
      assign new_hi_w[g] = hi_w[g] && (!side_hi_r[g] || hl != hi_last_r[g*TW +: TW]);
      assign new_lo_w[g] = lo_w[g] && (!side_lo_r[g] || ll != lo_last_r[g*TW +: TW]);
      // in default mode trip limits reach the interrupt at once, unfiltered, once per crossing
      assign trip_hi_w[g] = t > eff;
      assign new_trip_w[g] = trip_hi_w[g] && !side_trip_r[g];
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          side_hi_r[g] <= 1'b0;
          side_lo_r[g] <= 1'b0;
          side_trip_r[g] <= 1'b0;
          hi_last_r[g*TW +: TW] <= '0;
          lo_last_r[g*TW +: TW] <= '0;
        end else if (temp_cmp_i[g]) begin
          side_hi_r[g] <= hi_w[g];
          side_lo_r[g] <= lo_w[g];
          side_trip_r[g] <= trip_hi_w[g];
          hi_last_r[g*TW +: TW] <= hl;
          lo_last_r[g*TW +: TW] <= ll;
        end
      end
      hmi_trip #(
        .W(TW)
      ) u_trip (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .soft_rst_i(soft_rst_r),
        .cmp_i(temp_cmp_i[g]),
        .temp_i(t),
        .limit_i(eff),
        .clear_i(trip_clr),
        .trip_o(trip_w[g])
      );
    end
  endgenerate
  wire any_trip = |trip_w;
  wire temp_evt = |(temp_cmp_i & (new_hi_w | new_lo_w | new_trip_w));
  wire any_hi_cmp = |(temp_cmp_i & hi_w);
  wire any_lo_cmp = |(temp_cmp_i & lo_w);
  // ************
  // status, mirror, interrupt
  // ************
  logic [NSTAT-1:0] stat_nxt;
  logic [NSTAT-1:0] mirror_nxt;
  logic [NSTAT-1:0] set_w;
  wire [NSTAT-1:0] rd_clr = {{HALF{stat_rd_i[1]}}, {(NSTAT-HALF){stat_rd_i[0]}}};
  always_comb begin
    set_w = meas_upd_i & meas_oor_i;
    set_w[THERMAL_ALARM_N_IDX] = set_w[THERMAL_ALARM_N_IDX] | ext_thermal_alarm_n | (!acpi && temp_evt);
    // read clears, but a same-cycle set wins
    stat_nxt = (int_stat_o & ~rd_clr) | set_w;
    // mirror tracks every update and ignores reads
    mirror_nxt = (int_mirror_o & ~meas_upd_i) | set_w;
  end
  wire [NSTAT-1:0] temp_bit = {{(NSTAT-1-THERMAL_ALARM_N_IDX){1'b0}}, 1'b1, {THERMAL_ALARM_N_IDX{1'b0}}};
  wire [NSTAT-1:0] eff_mask = int_mask_i | (temp_mask ? temp_bit : '0);
  wire any_src = |(stat_nxt & ~eff_mask) | (|ext_req);
  wire int_drive = any_src && int_en && !int_clr;
  // ************
  // thermal alarm, default and ACPI modes
  // ************
  logic sw_alarm_r;
  logic sw_alarm_nxt;
  always_comb begin
    sw_alarm_nxt = sw_alarm_r;
    if (any_hi_cmp) begin
      sw_alarm_nxt = 1'b1;
    end else if (any_lo_cmp) begin
      sw_alarm_nxt = 1'b0;
    end
    if (stat_rd_i[1] && !any_hi_cmp) begin
      sw_alarm_nxt = 1'b0;
    end
    if (thermal_alarm_n_clr || acpi) begin
      sw_alarm_nxt = 1'b0;
    end
  end
  // default mode: software limits plus trips; ACPI: trips only
  wire alarm_drive = thermal_alarm_n_en && (any_trip || (!acpi && sw_alarm_nxt));
  wire fan_force = any_trip || ext_thermal_alarm_n;
  // ************
  // reset pulse generator
  // ************
  hmi_pulse_st_t pst_r;
  hmi_pulse_st_t pst_nxt;
  logic [24:0] pcnt_r;
  wire go = cfg1_i[`HMI_CFG1_RST_GO] && rst_pulse_en_i && cfg1_we_i;
  wire pdone = (pcnt_r == RST_LAST);
  always_comb begin
    pst_nxt = pst_r;
    unique case (pst_r)
      HMI_PULSE_IDLE: begin
        if (go) begin
          pst_nxt = HMI_PULSE_LOW;
        end
      end
      HMI_PULSE_LOW: begin
        if (pdone) begin
          pst_nxt = HMI_PULSE_IDLE;
        end
      end
      default: pst_nxt = HMI_PULSE_IDLE;
    endcase
  end
  // ************
  // registers
  // ************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_stat_o <= '0;
      int_mirror_o <= '0;
      sw_alarm_r <= 1'b0;
      pst_r <= HMI_PULSE_IDLE;
      pcnt_r <= 25'h0;
    end else if (soft_rst_r) begin
      int_stat_o <= '0;
      int_mirror_o <= '0;
      sw_alarm_r <= 1'b0;
      pst_r <= HMI_PULSE_IDLE;
      pcnt_r <= 25'h0;
    end else begin
      int_stat_o <= stat_nxt;
      int_mirror_o <= mirror_nxt;
      sw_alarm_r <= sw_alarm_nxt;
      pst_r <= pst_nxt;
      pcnt_r <= (pst_r == HMI_PULSE_LOW && !pdone) ? pcnt_r + 25'h1 : 25'h0;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_oe_o <= 1'b0;
      thermal_alarm_n_oe_o <= 1'b0;
      reset_oe_o <= 1'b0;
      rst_go_done_o <= 1'b0;
      soft_rst_o <= 1'b0;
      fan_code_o <= `HMI_FAN_FULL;
      ext_req_o <= 5'h00;
      trip_err_o <= '0;
    end else begin
      int_oe_o <= int_drive && !soft_rst_r;
      thermal_alarm_n_oe_o <= alarm_drive && !soft_rst_r;
      reset_oe_o <= (pst_nxt == HMI_PULSE_LOW);
      // self-clear strobe for config1 bit 4 once the pulse ends
      rst_go_done_o <= (pst_r == HMI_PULSE_LOW) && pdone;
      soft_rst_o <= soft_rst_r;
      fan_code_o <= fan_force ? `HMI_FAN_FULL : fan_code_i;
      ext_req_o <= ext_req;
      trip_err_o <= trip_w;
    end
  end
endmodule // hmi_top

// File: tb/hmi_top_asserts.sv
// concurrent checks on the interrupt and alarm block ports
`timescale 1ns/100ps
module hmi_top_asserts #(
  parameter int NSTAT = 16,
  parameter int NTEMP = 2,
  parameter int RST_CYC = 10
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] cfg1_i,
  input wire logic cfg1_we_i,
  input wire logic [7:0] cfg2_i,
  input wire logic [7:0] chan_mode_i,
  input wire logic [NSTAT-1:0] int_mask_i,
  input wire logic rst_pulse_en_i,
  input wire logic [NSTAT-1:0] meas_upd_i,
  input wire logic [NSTAT-1:0] meas_oor_i,
  input wire logic [NTEMP-1:0] temp_cmp_i,
  input wire logic [1:0] stat_rd_i,
  input wire logic [4:0] volt_id_i,
  input wire logic thermal_alarm_n_i,
  input wire logic [NSTAT-1:0] int_stat_o,
  input wire logic [NSTAT-1:0] int_mirror_o,
  input wire logic [4:0] ext_req_o,
  input wire logic int_oe_o,
  input wire logic thermal_alarm_n_oe_o,
  input wire logic reset_oe_o,
  input wire logic [7:0] fan_code_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ************
  // pulse length counter
  // ************
  logic [31:0] hi_cnt_r;
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) hi_cnt_r <= '0;
    else hi_cnt_r <= reset_oe_o ? hi_cnt_r + 32'h1 : '0;
  sequence s_go;
    cfg1_we_i && cfg1_i[4] && rst_pulse_en_i && !reset_oe_o;
  endsequence
  sequence s_quiet_rd;
    stat_rd_i[0] && meas_upd_i[7:0] == 8'h00;
  endsequence
  a_int_gate: assert property (int_oe_o |-> $past(cfg1_i[1]) && !$past(cfg1_i[3]))
    else $error("int drives while gated");
  a_unmasked_int: assert property (meas_upd_i[0] && meas_oor_i[0] && !int_mask_i[0]
    && cfg1_i[1] && !cfg1_i[3] |=> int_oe_o) else $error("int missing");
  a_clear_keeps: assert property (cfg1_i[3] && meas_upd_i == '0 && stat_rd_i == 2'h0
    && temp_cmp_i == '0 && thermal_alarm_n_i |=> $stable(int_stat_o)) else $error("stat lost");
  a_read_clears: assert property (s_quiet_rd |=> int_stat_o[7:0] == 8'h00)
    else $error("read did not clear");
  a_mirror_keep: assert property (s_quiet_rd |=> $stable(int_mirror_o[7:0]))
    else $error("mirror cleared by read");
  a_mirror_copy: assert property (meas_upd_i != '0
    |=> ((int_mirror_o ^ $past(meas_oor_i)) & $past(meas_upd_i)) == '0) else $error("mirror");
  a_req_off: assert property (!chan_mode_i[7] |=> ext_req_o == 5'h00)
    else $error("request outside mode");
  a_req_levels: assert property (chan_mode_i[7:4] == 4'hF && cfg2_i[7:6] == 2'h3
    |=> ext_req_o == {$past(volt_id_i[4:3]), ~$past(volt_id_i[2:0])}) else $error("levels");
  a_pulse_starts: assert property (s_go |=> reset_oe_o [*8])
    else $error("pulse short");
  a_pulse_refused: assert property (cfg1_we_i && !rst_pulse_en_i && !reset_oe_o
    |=> !reset_oe_o) else $error("pulse not refused");
  a_pulse_len: assert property ($fell(reset_oe_o) |-> hi_cnt_r == RST_CYC)
    else $error("pulse length");
  a_fan_forced: assert property (!thermal_alarm_n_i && !thermal_alarm_n_oe_o
    |-> ##[1:3] fan_code_o == 8'hFF) else $error("fan not full");
endmodule // hmi_top_asserts
bind hmi_top hmi_top_asserts #(.NSTAT(NSTAT), .NTEMP(NTEMP), .RST_CYC(RST_CYC)) chk_u (.*);

// File: tb/hmi_host.sv
// host side model: pulled-up pins plus an outside thermal sensor
`timescale 1ns/100ps
module hmi_host (
  input wire logic int_oe_i,
  input wire logic alarm_oe_i,
  input wire logic sensor_pull_i,
  output logic int_n_o,
  output logic alarm_n_o
);
  // pull-ups: a released pin reads high, never the last driven level
  assign int_n_o = !int_oe_i;
  assign alarm_n_o = !(alarm_oe_i || sensor_pull_i);
endmodule // hmi_host

// File: tb/hmi_top_tb.sv
// self-checking bench for the interrupt and alarm block
`timescale 1ns/100ps
`define CHK(n, e, s) check_count++; \
  if ((s) !== (e)) begin errors++; $display("BAD %s exp %h got %h", n, e, s); end
module hmi_top_tb;
  localparam int RC = 10;
  typedef struct {int k; logic [15:0] e;} hmi_note_t;
  logic clk_i, rst_n_i, cfg1_we_i, rst_pulse_en_i, ext_rst_n_i, ext_pull;
  logic [7:0] cfg1_i, cfg2_i, chan_mode_i, fan_code_i, fan_code_o;
  logic [15:0] int_mask_i, meas_upd_i, meas_oor_i, temp_i, temp_high_i, temp_low_i;
  logic [15:0] trip_lim_i, fixed_trip_i, int_stat_o, int_mirror_o;
  logic [1:0] stat_rd_i, temp_cmp_i, trip_err_o;
  logic [4:0] volt_id_i, ext_req_o, v, en;
  logic thermal_alarm_n_i, int_oe_o, thermal_alarm_n_oe_o, reset_oe_o, rst_go_done_o, soft_rst_o;
  int errors, check_count, plen, i, k, go_cnt, sr_cnt;
  hmi_note_t q[$];
  string nm[9] = '{"stat", "mirror", "int", "req", "fan", "trip", "alarm", "pulse", "strobes"};
  wire [143:0] obs_v = {go_cnt[7:0], sr_cnt[7:0], plen[15:0], 15'h0, thermal_alarm_n_oe_o,
    14'h0, trip_err_o, 8'h0,
    fan_code_o, 11'h0, ext_req_o, 15'h0, int_oe_o, int_mirror_o, int_stat_o};
  hmi_top #(.RST_CYC(RC)) dut_u (.*);
  hmi_host host_u (.int_oe_i(int_oe_o), .alarm_oe_i(thermal_alarm_n_oe_o),
    .sensor_pull_i(ext_pull), .int_n_o(), .alarm_n_o(thermal_alarm_n_i));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // ************
  // tasks
  // ************
  task cyc(int n);
    repeat (n) @(posedge clk_i);
  endtask
  task note(int n, logic [15:0] e);
    q.push_back('{n, e});
  endtask
  task upd(int b);
    {meas_upd_i, meas_oor_i} <= {2{16'h1 << b}};
    cyc(1);
    {meas_upd_i, meas_oor_i} <= 32'h0;
  endtask
  task rd(logic [1:0] w);
    stat_rd_i <= w;
    cyc(1);
    stat_rd_i <= 2'h0;
  endtask
  task cmp3;
    repeat (3) begin
      temp_cmp_i <= 2'h1;
      cyc(1);
      temp_cmp_i <= 2'h0;
      cyc(1);
    end
    cyc(2);
  endtask
  task cmp1;
    temp_cmp_i <= 2'h1;
    cyc(1);
    temp_cmp_i <= 2'h0;
    cyc(2);
  endtask
  task tdone(string s);
    $display("finished %s", s);
  endtask
  task results;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // strobe widths: every cycle a strobe stands high adds one
  always @(negedge clk_i) begin
    go_cnt += int'(rst_go_done_o);
    sr_cnt += int'(soft_rst_o);
  end
  // compares outputs at the falling edge, once the driving edge has settled
  initial begin : mon
    hmi_note_t n;
    forever begin
      @(negedge clk_i);
      while (q.size() > 0) begin
        n = q.pop_front();
        `CHK(nm[n.k], n.e, obs_v[n.k*16 +: 16])
      end
    end
  end
  initial begin
    {rst_n_i, cfg1_we_i, rst_pulse_en_i, ext_pull, ext_rst_n_i} = 5'h01;
    {cfg1_i, cfg2_i, chan_mode_i, stat_rd_i, temp_cmp_i, volt_id_i} = 33'h0;
    {int_mask_i, meas_upd_i, meas_oor_i, temp_i, temp_low_i} = 80'h0;
    {temp_high_i, trip_lim_i, fixed_trip_i} = 48'h7F7F_4040_5050;
    void'($urandom(32'hF5C7));
    fan_code_i = 8'($urandom);
    cyc(8);
    rst_n_i <= 1'b1;
    cfg1_i <= 8'h03;
    cyc(1);
    upd(0);
    note(0, 16'h0001);
    note(1, 16'h0001);
    note(2, 16'h0001);
    rd(2'h1);
    note(0, 16'h0000);
    note(1, 16'h0001);
    note(2, 16'h0000);
    k = $urandom_range(7, 1);
    int_mask_i <= 16'h1 << k;
    upd(k);
    note(2, 16'h0000);
    note(0, 16'h1 << k);
    rd(2'h1);
    int_mask_i <= 16'h0000;
    tdone("status");
    upd(1);
    cfg1_i <= 8'h0B;
    cyc(2);
    note(2, 16'h0000);
    note(0, 16'h0002);
    cfg1_i <= 8'h01;
    cyc(2);
    note(2, 16'h0000);
    cfg1_i <= 8'h03;
    cyc(2);
    note(2, 16'h0001);
    rd(2'h1);
    tdone("clear");
    for (i = 0; i < 6; i++) begin
      v = 5'($urandom);
      en = (i < 3) ? 5'h1F : 5'($urandom);
      volt_id_i <= v;
      chan_mode_i <= {1'b1, en[2:0], 4'h0};
      cfg2_i <= {en[4:3], 6'h00};
      cyc(2);
      note(3, {11'h0, {v[4:3], ~v[2:0]} & en});
    end
    chan_mode_i <= 8'h70;
    cyc(2);
    note(3, 16'h0000);
    {chan_mode_i, cfg2_i, volt_id_i} <= 21'h0;
    tdone("requests");
    ext_pull <= 1'b1;
    cyc(4);
    note(4, 16'h00FF);
    ext_pull <= 1'b0;
    cyc(4);
    note(4, {8'h0, fan_code_i});
    note(0, 16'h2000);
    rd(2'h2);
    tdone("alarm input");
    {cfg1_i, cfg1_we_i} <= 9'h127;
    cyc(1);
    cfg1_we_i <= 1'b0;
    plen = 0;
    repeat (5) begin
      cyc(1);
      plen += int'(reset_oe_o);
    end
    note(7, 16'h0000);
    {rst_pulse_en_i, cfg1_we_i} <= 2'h3;
    cyc(1);
    cfg1_we_i <= 1'b0;
    cfg1_i <= 8'h03;
    for (i = 0; i < 20 && reset_oe_o !== 1'b1; i++) cyc(1);
    for (plen = 0; plen < 100 && reset_oe_o === 1'b1; plen++) cyc(1);
    if (i == 20 || plen == 100) begin
      errors++;
      results();
    end
    note(7, 16'(RC));
    note(8, 16'h0100);
    tdone("reset pulse");
    cfg1_i <= 8'h05;
    temp_i <= 16'h0048;
    cmp3();
    note(5, 16'h0001);
    note(6, 16'h0001);
    note(4, 16'h00FF);
    rd(2'h3);
    note(5, 16'h0001);
    cfg2_i <= 8'h01;
    cyc(3);
    note(5, 16'h0000);
    cfg2_i <= 8'h08;
    cmp3();
    note(6, 16'h0001);
    note(4, 16'h00FF);
    temp_i <= 16'h003B;
    cmp3();
    note(6, 16'h0000);
    note(4, {8'h0, fan_code_i});
    tdone("trip");
    {cfg1_i, cfg2_i} <= 16'h0700;
    temp_high_i <= 16'h7F30;
    temp_i <= 16'h0032;
    cmp1();
    note(0, 16'h2000);
    note(2, 16'h0001);
    note(6, 16'h0001);
    note(4, {8'h0, fan_code_i});
    rd(2'h2);
    note(0, 16'h0000);
    note(6, 16'h0000);
    cmp1();
    note(0, 16'h0000);
    note(2, 16'h0000);
    note(6, 16'h0001);
    cfg1_i <= 8'h47;
    cmp1();
    note(6, 16'h0000);
    cfg1_i <= 8'h07;
    cmp1();
    note(6, 16'h0001);
    cfg2_i <= 8'h01;
    temp_high_i <= 16'h7F31;
    cmp1();
    note(0, 16'h2000);
    note(2, 16'h0000);
    note(6, 16'h0001);
    cfg2_i <= 8'h00;
    cyc(2);
    note(2, 16'h0001);
    rd(2'h2);
    {temp_i, temp_low_i} <= 32'h0010_0020;
    cmp1();
    note(0, 16'h2000);
    note(6, 16'h0000);
    cfg1_i <= 8'h03;
    temp_i <= 16'h0032;
    cmp1();
    note(6, 16'h0000);
    tdone("limits");
    upd(2);
    ext_rst_n_i <= 1'b0;
    cyc(2);
    ext_rst_n_i <= 1'b1;
    cyc(2);
    note(0, 16'h0000);
    note(1, 16'h0000);
    note(2, 16'h0000);
    note(4, {8'h0, fan_code_i});
    note(8, 16'h0101);
    tdone("pin reset");
    cyc(3);
    results();
  end
endmodule // hmi_top_tb
